// file: hdl/mis_pkg.sv
// Shared constants and types for the skip, branch and OR execution block.
package mis_pkg;
  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int DATA_W  = 8;
  localparam int INSTR_W = 14;
  localparam int PC_W    = 13;
  localparam int FADDR_W = 7;
  localparam int KBR_W   = 11;

  // ----------------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------------
  localparam int OP_HI     = 13;
  localparam int OP_LO     = 8;
  localparam int DEST_BIT  = 7;
  localparam int BR_OP_LO  = 11;
  localparam int LATCH_HI  = 4;
  localparam int LATCH_LO  = 3;

  // ----------------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------------
  localparam logic [5:0] OP_OR_WORKING_WITH_FILE    = 6'h04;
  localparam logic [5:0] OP_INCREMENT_FILE          = 6'h0a;
  localparam logic [5:0] OP_DECREMENT_SKIP_IF_ZERO  = 6'h0b;
  localparam logic [5:0] OP_INCREMENT_SKIP_IF_ZERO  = 6'h0f;
  localparam logic [5:0] OP_OR_LITERAL_INTO_WORKING = 6'h38;
  localparam logic [2:0] OP_UNCONDITIONAL_BRANCH    = 3'h5;

  // ----------------------------------------------------------------------
  // Reset values and step constants
  // ----------------------------------------------------------------------
  localparam logic [DATA_W-1:0]  WORKING_RESET = 8'h00;
  localparam logic               ZERO_RESET    = 1'b0;
  localparam logic [PC_W-1:0]    PC_RESET      = 13'h0000;
  localparam logic [FADDR_W-1:0] FADDR_RESET   = 7'h00;
  localparam logic [PC_W-1:0]    PC_STEP       = 13'h0001;
  localparam logic [DATA_W-1:0]  DATA_ONE      = 8'h01;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_FLUSH = 2'b10
  } mis_state_type;
endpackage : mis_pkg

// file: hdl/mis_exec_if.sv
// Carrier between the sequencing core and its execution unit.
`timescale 1ns/100ps
interface mis_exec_if;
  import mis_pkg::*;
  logic [INSTR_W-1:0] instrWord;
  logic [DATA_W-1:0]  fileData;
  logic [DATA_W-1:0]  workingIn;
  logic [DATA_W-1:0]  result;
  logic               resZero;
  logic               toFile;
  logic               toWorking;
  logic               setsZero;
  logic               doSkip;
  logic               doBranch;

  modport core (output instrWord, fileData, workingIn,
                input  result, resZero, toFile, toWorking, setsZero,
                       doSkip, doBranch);
  modport unit (input  instrWord, fileData, workingIn,
                output result, resZero, toFile, toWorking, setsZero,
                       doSkip, doBranch);
endinterface : mis_exec_if

// file: hdl/mis_exec_unit.sv
// Combinational decode and arithmetic for the supported instructions.
`timescale 1ns/100ps
module mis_exec_unit
  import mis_pkg::*;
(
  mis_exec_if.unit ex
);
  logic [5:0] opcode;
  logic       dest;

  assign opcode = ex.instrWord[OP_HI:OP_LO];
  assign dest   = ex.instrWord[DEST_BIT];

  always_comb begin
    ex.result    = ex.workingIn;
    ex.toFile    = 1'b0;
    ex.toWorking = 1'b0;
    ex.setsZero  = 1'b0;
    ex.doSkip    = 1'b0;
    ex.doBranch  = 1'b0;
    if (ex.instrWord[OP_HI:BR_OP_LO] == OP_UNCONDITIONAL_BRANCH) begin
      ex.doBranch = 1'b1;
    end else begin
      case (opcode)
        OP_DECREMENT_SKIP_IF_ZERO: begin
          ex.result    = ex.fileData - DATA_ONE;
          ex.toFile    = dest;
          ex.toWorking = !dest;
          ex.doSkip    = (ex.result == '0);
        end
        OP_INCREMENT_SKIP_IF_ZERO: begin
          ex.result    = ex.fileData + DATA_ONE;
          ex.toFile    = dest;
          ex.toWorking = !dest;
          ex.doSkip    = (ex.result == '0);
        end
        OP_INCREMENT_FILE: begin
          ex.result    = ex.fileData + DATA_ONE;
          ex.toFile    = dest;
          ex.toWorking = !dest;
          ex.setsZero  = 1'b1;
        end
        OP_OR_LITERAL_INTO_WORKING: begin
          ex.result    = ex.workingIn | ex.instrWord[DATA_W-1:0];
          ex.toWorking = 1'b1;
          ex.setsZero  = 1'b1;
        end
        OP_OR_WORKING_WITH_FILE: begin
          ex.result    = ex.workingIn | ex.fileData;
          ex.toFile    = dest;
          ex.toWorking = !dest;
          ex.setsZero  = 1'b1;
        end
        default: begin
          ex.result = ex.workingIn;
        end
      endcase
    end
  end

  assign ex.resZero = (ex.result == '0);
endmodule : mis_exec_unit

// file: hdl/mis_core.sv
// Sequencing core: working register, zero flag, program counter, skips.
`timescale 1ns/100ps
module mis_core
  import mis_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               instrValid,
  input  wire logic [INSTR_W-1:0] instrWord,
  input  wire logic [DATA_W-1:0]  fileReadData,
  input  wire logic [DATA_W-1:0]  pcHighLatch,
  output logic      [FADDR_W-1:0] fileWriteAddr,
  output logic                    fileWriteEn,
  output logic      [DATA_W-1:0]  fileWriteData,
  output logic      [DATA_W-1:0]  workingReg,
  output logic                    zeroFlag,
  output logic      [PC_W-1:0]    programCounter,
  output logic                    discardNext
);
  // ----------------------------------------------------------------------
  // Execution unit
  // ----------------------------------------------------------------------
  mis_exec_if ex ();

  assign ex.instrWord = instrWord;
  assign ex.fileData  = fileReadData;
  assign ex.workingIn = workingReg;

  mis_exec_unit u_exec (
    .ex (ex.unit)
  );

  // ----------------------------------------------------------------------
  // Sequencing state
  // ----------------------------------------------------------------------
  // A taken branch and a taken skip share one mechanism: the instruction
  // already fetched behind them is squashed, which costs the second cycle.
  mis_state_type      state;
  mis_state_type      next_state;
  logic [DATA_W-1:0]  next_workingReg;
  logic               next_zeroFlag;
  logic [PC_W-1:0]    next_programCounter;
  logic               next_fileWriteEn;
  logic [DATA_W-1:0]  next_fileWriteData;
  logic [FADDR_W-1:0] next_fileWriteAddr;

  always_comb begin
    next_state          = state;
    next_workingReg     = workingReg;
    next_zeroFlag       = zeroFlag;
    next_programCounter = programCounter;
    next_fileWriteEn    = 1'b0;
    next_fileWriteData  = fileWriteData;
    next_fileWriteAddr  = fileWriteAddr;
    if (instrValid) begin
      next_programCounter = programCounter + PC_STEP;
      case (state)
        ST_RUN: begin
          if (ex.toWorking) begin
            next_workingReg = ex.result;
          end
          if (ex.toFile) begin
            next_fileWriteEn   = 1'b1;
            next_fileWriteData = ex.result;
            next_fileWriteAddr = instrWord[FADDR_W-1:0];
          end
          if (ex.setsZero) begin
            next_zeroFlag = ex.resZero;
          end
          if (ex.doBranch) begin
            next_programCounter = {pcHighLatch[LATCH_HI:LATCH_LO],
                                   instrWord[KBR_W-1:0]};
          end
          if (ex.doSkip || ex.doBranch) begin
            next_state = ST_FLUSH;
          end
        end
        ST_FLUSH: begin
          // The squashed slot only advances the counter, like a no-op.
          next_state = ST_RUN;
        end
        default: begin
          next_state = ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state          <= ST_RUN;
      workingReg     <= WORKING_RESET;
      zeroFlag       <= ZERO_RESET;
      programCounter <= PC_RESET;
      fileWriteEn    <= 1'b0;
      fileWriteData  <= WORKING_RESET;
      fileWriteAddr  <= FADDR_RESET;
    end else begin
      state          <= next_state;
      workingReg     <= next_workingReg;
      zeroFlag       <= next_zeroFlag;
      programCounter <= next_programCounter;
      fileWriteEn    <= next_fileWriteEn;
      fileWriteData  <= next_fileWriteData;
      fileWriteAddr  <= next_fileWriteAddr;
    end
  end

  assign discardNext = state[1];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic live;
  logic [5:0] opc;
  assign live = instrValid && (state == ST_RUN);
  assign opc  = instrWord[OP_HI:OP_LO];

  chk_dec_to_working: assert property (
    @(posedge clk_sys) disable iff (rst)
    live && opc == OP_DECREMENT_SKIP_IF_ZERO && !instrWord[DEST_BIT]
    |=> workingReg == 8'($past(fileReadData) - DATA_ONE)
        && $stable(zeroFlag) && !fileWriteEn)
    else $error("decrement result not placed in working register");

  chk_dec_to_file: assert property (
    @(posedge clk_sys) disable iff (rst)
    live && opc == OP_DECREMENT_SKIP_IF_ZERO && instrWord[DEST_BIT]
    |=> fileWriteEn && $stable(workingReg) && $stable(zeroFlag)
        && fileWriteData == 8'($past(fileReadData) - DATA_ONE)
        && fileWriteAddr == $past(instrWord[FADDR_W-1:0]))
    else $error("decrement result not placed in file register");

  chk_dec_zero_skip: assert property (
    @(posedge clk_sys) disable iff (rst)
    live && opc == OP_DECREMENT_SKIP_IF_ZERO
    |=> discardNext == ($past(fileReadData) == DATA_ONE))
    else $error("decrement skip decision wrong");

  chk_inc_skip_file: assert property (
    @(posedge clk_sys) disable iff (rst)
    live && opc == OP_INCREMENT_SKIP_IF_ZERO && instrWord[DEST_BIT]
    |=> fileWriteEn && fileWriteData == 8'($past(fileReadData) + DATA_ONE)
        && discardNext == ($past(fileReadData) == 8'hff)
        && $stable(zeroFlag))
    else $error("increment skip wrong");

  chk_inc_to_working: assert property (
    @(posedge clk_sys) disable iff (rst)
    live && opc == OP_INCREMENT_SKIP_IF_ZERO && !instrWord[DEST_BIT]
    |=> workingReg == 8'($past(fileReadData) + DATA_ONE)
        && discardNext == ($past(fileReadData) == 8'hff)
        && $stable(zeroFlag) && !fileWriteEn)
    else $error("increment result not placed in working register");

  chk_branch_target: assert property (
    @(posedge clk_sys) disable iff (rst)
    live && instrWord[OP_HI:BR_OP_LO] == OP_UNCONDITIONAL_BRANCH
    |=> programCounter == {$past(pcHighLatch[LATCH_HI:LATCH_LO]),
                           $past(instrWord[KBR_W-1:0])})
    else $error("branch target wrong");

  chk_branch_two_cycle: assert property (
    @(posedge clk_sys) disable iff (rst)
    live && instrWord[OP_HI:BR_OP_LO] == OP_UNCONDITIONAL_BRANCH
    |=> discardNext && !fileWriteEn
        && $stable(zeroFlag) && $stable(workingReg))
    else $error("branch did not squash next slot");

  // A squashed slot must behave as a no-op: only the counter moves, and
  // the squash is spent so that the instruction after it runs normally.
  chk_squash_slot: assert property (
    @(posedge clk_sys) disable iff (rst)
    instrValid && discardNext
    |=> !fileWriteEn && !discardNext
        && $stable(workingReg) && $stable(zeroFlag)
        && programCounter == PC_W'($past(programCounter) + PC_STEP))
    else $error("squashed slot was not a no-op");

  chk_pc_advance: assert property (
    @(posedge clk_sys) disable iff (rst)
    live && instrWord[OP_HI:BR_OP_LO] != OP_UNCONDITIONAL_BRANCH
    |=> programCounter == PC_W'($past(programCounter) + PC_STEP))
    else $error("counter did not step past a plain instruction");

  chk_or_literal: assert property (
    @(posedge clk_sys) disable iff (rst)
    live && opc == OP_OR_LITERAL_INTO_WORKING
    |=> workingReg == ($past(workingReg) | $past(instrWord[DATA_W-1:0]))
        && zeroFlag == (workingReg == 8'h00))
    else $error("literal OR wrong");

  chk_or_file: assert property (
    @(posedge clk_sys) disable iff (rst)
    live && opc == OP_OR_WORKING_WITH_FILE && instrWord[DEST_BIT]
    |=> fileWriteEn && $stable(workingReg)
        && fileWriteData == ($past(workingReg) | $past(fileReadData))
        && zeroFlag == (fileWriteData == 8'h00))
    else $error("file OR wrong");

  cov_dec_skip: cover property (
    @(posedge clk_sys) disable iff (rst)
    live && opc == OP_DECREMENT_SKIP_IF_ZERO ##1 discardNext);
  cov_inc_skip: cover property (
    @(posedge clk_sys) disable iff (rst)
    live && opc == OP_INCREMENT_SKIP_IF_ZERO ##1 discardNext);
  cov_branch: cover property (
    @(posedge clk_sys) disable iff (rst)
    live && instrWord[OP_HI:BR_OP_LO] == OP_UNCONDITIONAL_BRANCH
    ##1 discardNext && instrValid);
  cov_or_zero: cover property (
    @(posedge clk_sys) disable iff (rst)
    live && opc == OP_OR_WORKING_WITH_FILE ##1 zeroFlag);
  cov_squash: cover property (
    @(posedge clk_sys) disable iff (rst)
    instrValid && discardNext ##1 !discardNext);
endmodule : mis_core

// file: dv/mcu_core_incdec_skip_branch_or_bench.sv
// Self-checking bench for the skip, branch and OR sequencing core.
`timescale 1ns/100ps
module mcu_core_incdec_skip_branch_or_bench
  import mis_pkg::*;
;
  // ----------------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------------
  localparam int LIMIT = 2000;
  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  logic               instrValid = 1'b0;
  logic [INSTR_W-1:0] instrWord = '0;
  logic [DATA_W-1:0]  fileReadData = '0;
  logic [DATA_W-1:0]  pcHighLatch = '0;
  logic [FADDR_W-1:0] fileWriteAddr;
  logic               fileWriteEn;
  logic [DATA_W-1:0]  fileWriteData;
  logic [DATA_W-1:0]  workingReg;
  logic               zeroFlag;
  logic [PC_W-1:0]    programCounter;
  logic               discardNext;
  logic [PC_W-1:0]    expPc = '0;
  int                 failures = 0;
  int                 compares = 0;
  int                 cycles = 0;

  always #2 clk_sys = ~clk_sys;

  mis_core DUT (
    .clk_sys        (clk_sys),
    .rst            (rst),
    .instrValid     (instrValid),
    .instrWord      (instrWord),
    .fileReadData   (fileReadData),
    .pcHighLatch    (pcHighLatch),
    .fileWriteAddr  (fileWriteAddr),
    .fileWriteEn    (fileWriteEn),
    .fileWriteData  (fileWriteData),
    .workingReg     (workingReg),
    .zeroFlag       (zeroFlag),
    .programCounter (programCounter),
    .discardNext    (discardNext)
  );

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One idle cycle separates instructions so valid is never driven twice
  // in one time step; outputs are sampled 1 ns after the taking edge.
  task automatic issue(input logic [INSTR_W-1:0] w,
                       input logic [DATA_W-1:0]  f);
    @(posedge clk_sys);
    instrValid   <= 1'b1;
    instrWord    <= w;
    fileReadData <= f;
    @(posedge clk_sys);
    instrValid <= 1'b0;
    #1;
    expPc = expPc + PC_STEP;
  endtask : issue

  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic test_or_ops();
    issue({OP_OR_LITERAL_INTO_WORKING, 8'h00}, 8'h00);
    check(workingReg, 8'h00);
    check(zeroFlag, 1'b1);
    issue({OP_OR_LITERAL_INTO_WORKING, 8'h5a}, 8'h00);
    check(workingReg, 8'h5a);
    check(zeroFlag, 1'b0);
    issue({OP_OR_WORKING_WITH_FILE, 1'b0, 7'h11}, 8'h81);
    check(workingReg, 8'hdb);
    check(fileWriteEn, 1'b0);
    issue({OP_OR_WORKING_WITH_FILE, 1'b1, 7'h23}, 8'h24);
    check(fileWriteEn, 1'b1);
    check(fileWriteData, 8'hff);
    check(fileWriteAddr, 7'h23);
    check(workingReg, 8'hdb);
    check(programCounter, expPc);
    @(posedge clk_sys);
    #1;
    check(fileWriteEn, 1'b0);
    $display("test or_ops done");
  endtask : test_or_ops

  // The squashed slots carry ORs: the first would set the flag, the second would change W.
  task automatic test_skips();
    issue({OP_DECREMENT_SKIP_IF_ZERO, 1'b0, 7'h05}, 8'h01);
    check(workingReg, 8'h00);
    check(zeroFlag, 1'b0);
    check(discardNext, 1'b1);
    issue({OP_OR_LITERAL_INTO_WORKING, 8'h00}, 8'h00);
    check(workingReg, 8'h00);
    check(zeroFlag, 1'b0);
    check(discardNext, 1'b0);
    check(programCounter, expPc);
    issue({OP_DECREMENT_SKIP_IF_ZERO, 1'b1, 7'h7f}, 8'h05);
    check(fileWriteData, 8'h04);
    check(fileWriteAddr, 7'h7f);
    check(discardNext, 1'b0);
    issue({OP_INCREMENT_SKIP_IF_ZERO, 1'b1, 7'h40}, 8'hff);
    check(fileWriteEn, 1'b1);
    check(fileWriteData, 8'h00);
    check(zeroFlag, 1'b0);
    check(discardNext, 1'b1);
    issue({OP_OR_LITERAL_INTO_WORKING, 8'h3c}, 8'h00);
    check(workingReg, 8'h00);
    check(discardNext, 1'b0);
    issue({OP_INCREMENT_SKIP_IF_ZERO, 1'b0, 7'h01}, 8'h10);
    check(workingReg, 8'h11);
    check(discardNext, 1'b0);
    check(programCounter, expPc);
    issue({OP_INCREMENT_FILE, 1'b1, 7'h02}, 8'hff);
    check(fileWriteData, 8'h00);
    check(zeroFlag, 1'b1);
    check(discardNext, 1'b0);
    $display("test skips done");
  endtask : test_skips

  // One call sets only latch bits 4:3, the other only those outside 4:3, to catch a wrong page slice.
  task automatic test_branch(input logic [DATA_W-1:0] latch,
                             input logic [KBR_W-1:0]  k);
    @(posedge clk_sys);
    pcHighLatch <= latch;
    issue({OP_UNCONDITIONAL_BRANCH, k}, 8'h00);
    expPc = {latch[LATCH_HI:LATCH_LO], k};
    check(programCounter, expPc);
    check(discardNext, 1'b1);
    check(zeroFlag, 1'b1);
    issue({OP_OR_LITERAL_INTO_WORKING, 8'h80}, 8'h00);
    check(programCounter, expPc);
    check(workingReg, 8'h11);
    check(zeroFlag, 1'b1);
    $display("test branch done");
  endtask : test_branch

  // A reset in mid-run must also drop a pending squash.
  task automatic test_reset();
    issue({OP_DECREMENT_SKIP_IF_ZERO, 1'b0, 7'h02}, 8'h01);
    check(discardNext, 1'b1);
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    check(discardNext, 1'b0);
    check(workingReg, WORKING_RESET);
    check(programCounter, PC_RESET);
    expPc = PC_RESET;
    issue({OP_OR_LITERAL_INTO_WORKING, 8'h3c}, 8'h00);
    check(workingReg, 8'h3c);
    check(zeroFlag, 1'b0);
    check(programCounter, expPc);
    $display("test reset done");
  endtask : test_reset

  // ----------------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------------
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      summarize();
    end
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    check(workingReg, WORKING_RESET);
    check(zeroFlag, ZERO_RESET);
    check(programCounter, PC_RESET);
    check(discardNext, 1'b0);
    test_or_ops();
    test_skips();
    test_branch(8'h18, 11'h5a5);
    test_branch(8'he7, 11'h123);
    test_reset();
    summarize();
  end
endmodule : mcu_core_incdec_skip_branch_or_bench
